/* hw/lffm_fault_mgr.sv */
// Purpose: fault flags, masks, fault pin and output gating
// Assumes: detector inputs are synchronous levels from analog front end
// Notes: registers on apb, zero wait states
`include "lffm_map.svh"

// Overview of operation
// - masked open fault sets only the channel open flag, no pin
// - unmasked open fault sets channel, output, error flags, 50 us pulse
// - short flag always; unmasked also summaries and 50 us pulse
// - single-short flag always; unmasked also summaries and pulse
// - rail lockout gives power-on state, flags, constant pin low
// - normal undervoltage: outputs off, flag, maskable constant pin
// - normal reference fault: outputs kept, flag, maskable pin
// - normal overtemp: outputs off, flag latched, maskable pin
// - open and short evaluated only with channel and diag enable
// - single-short also needs global single-short enable
// - checksum mismatch sets checksum flag; unmasked also error flag and pulse
// - watchdog overflow enters fail-safe, flag; host exits by write
// - fail-safe with all-off set: any led fault on a channel- and diag-enabled channel kills all outputs
// - fail-safe with all-off clear: only faulty channel off
// - flags stay readable in fail-safe
// - power flag clear clears power and error flags, self clears
// - fail-safe low supply latches flags, cleared by fault clear
// - low supply suppresses open and single-short detection
// - low-supply threshold 4 V to 35 V in 1 V steps
// - fail-safe undervoltage: pin low, outputs off, auto recovery
// - fail-safe reference fault: outputs off, pin low, flags
// - watchdog period zero disables the watchdog
// - valid addressed frame restarts the watchdog
module lffm_fault_mgr
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rails_good,
  input wire logic supply_under,
  input wire logic ref_fault,
  input wire logic overtemp,
  input wire logic [15:0] open_det,
  input wire logic [15:0] short_det,
  input wire logic [15:0] single_short_det,
  input wire logic [5:0] supply_volts,
  input wire logic crc_check_done,
  input wire logic [7:0] nvm_checksum_computed,
  input wire logic [7:0] nvm_checksum_stored,
  input wire logic frame_ok,
  output logic [15:0] chan_out_on,
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  lffm_pkg::lffm_state_t state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [15:0] chan_enable_reg, chan_diag_enable_reg;
  logic [15:0] chan_open_flag, chan_short_flag, chan_single_short_flag;
  logic power_flag, err_flag, out_flag, low_supply_flag, supply_under_flag;
  logic ref_flag, overtemp_flag, nvm_checksum_flag, failsafe_flag;
  logic [12:0] pulse_cnt_reg;
  logic [9:0] wd_tick_reg;
  logic [3:0] wd_cnt_reg;
  logic [15:0] chan_off_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr = psel && penable && pwrite;
  wire rd_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  wire wr_ctrl = wr && paddr == `LFFM_CTRL_ADDR;
  wire wr_chen = wr && paddr == `LFFM_CHEN_ADDR;
  wire wr_clr = wr && paddr == `LFFM_CLR_ADDR;
  // clear bits are strobes: nothing is stored, so they read back as 0
  wire clr_por = wr_clr && pwdata[`LFFM_CLR_POR];
  wire clr_fault = wr_clr && pwdata[`LFFM_CLR_FAULT];
  wire clr_fs = wr_clr && pwdata[`LFFM_CLR_FS];
  wire is_normal = state_reg == lffm_pkg::LFFM_NORMAL;
  wire is_fs = state_reg == lffm_pkg::LFFM_FAILSAFE;
  wire running = is_normal || is_fs;
  wire m_open = ctrl_reg[`LFFM_CTRL_MOPEN];
  wire m_short = ctrl_reg[`LFFM_CTRL_MSHORT];
  wire m_sls = ctrl_reg[`LFFM_CTRL_MSLS];
  wire m_uv = ctrl_reg[`LFFM_CTRL_MSUPUV];
  wire m_ref = ctrl_reg[`LFFM_CTRL_MREF];
  wire m_tsd = ctrl_reg[`LFFM_CTRL_MTSD];
  wire m_crc = ctrl_reg[`LFFM_CTRL_MCRC];
  wire all_off_on_fault = ctrl_reg[`LFFM_CTRL_ALL_OFF_ON_FAULT];
  wire [3:0] wd_period = ctrl_reg[`LFFM_CTRL_WD_LSB +: 4];
  wire [4:0] lst_field = ctrl_reg[`LFFM_CTRL_LST_LSB +: 5];

  // field 0..31 is 4 V..35 V in 1 V steps
  function automatic logic [5:0] lst_volts(input logic [4:0] f);
    lst_volts = 6'(f) + 6'(`LFFM_LST_MIN_V);
  endfunction

  wire low_supply = supply_volts < lst_volts(lst_field);
  wire [15:0] diag_ok = chan_enable_reg & chan_diag_enable_reg;
  wire [15:0] open_ev = running && !low_supply ?
    open_det & diag_ok : 16'h0000;
  wire [15:0] short_ev = running ? short_det & diag_ok : 16'h0000;
  wire [15:0] sls_ev = running && !low_supply &&
    ctrl_reg[`LFFM_CTRL_SINGLE_SHORT_DETECT_EN] ? single_short_det & diag_ok : 16'h0000;
  wire crc_ev = running && crc_check_done &&
    nvm_checksum_computed != nvm_checksum_stored;
  wire open_rep = |open_ev && !m_open;
  wire short_rep = |short_ev && !m_short;
  wire sls_rep = |sls_ev && !m_sls;
  wire out_rep = open_rep || short_rep || sls_rep;
  wire pulse_req = out_rep || (crc_ev && !m_crc);
  wire uv_on = running && supply_under;
  wire ref_on = running && ref_fault;
  wire tsd_on = running && overtemp;
  wire lowsup_set = is_fs && low_supply;
  // fail-safe ignores masks: pin held for every active undervoltage, reference or overtemp level
  wire const_req = !rails_good || state_reg == lffm_pkg::LFFM_POR ||
    (uv_on && (is_fs || !m_uv)) || (ref_on && (is_fs || !m_ref)) ||
    (tsd_on && (is_fs || !m_tsd));
  wire err_set = (uv_on && !m_uv) || (ref_on && !m_ref) ||
    (tsd_on && !m_tsd) || pulse_req || lowsup_set ||
    (uv_on && is_fs) || (ref_on && is_fs);
  wire wd_tick = wd_tick_reg == 10'(`LFFM_WD_TICK_CYC - 1);
  wire wd_over = is_normal && wd_period != 4'h0 &&
    wd_cnt_reg == wd_period && wd_tick;
  wire [15:0] led_fault = open_det | short_det | single_short_det;
  wire [15:0] fs_kill = all_off_on_fault ? {16{|(led_fault & diag_ok)}} :
    led_fault & diag_ok;
  wire all_off = uv_on || tsd_on || (ref_on && is_fs);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      lffm_pkg::LFFM_POR: if (rails_good) state_next = lffm_pkg::LFFM_START;
      lffm_pkg::LFFM_START: state_next = lffm_pkg::LFFM_NORMAL;
      lffm_pkg::LFFM_NORMAL: if (wd_over) state_next = lffm_pkg::LFFM_FAILSAFE;
      lffm_pkg::LFFM_FAILSAFE: if (clr_fs) state_next = lffm_pkg::LFFM_NORMAL;
    endcase
    if (!rails_good)
      state_next = lffm_pkg::LFFM_POR;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= lffm_pkg::LFFM_POR;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // config registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `LFFM_CTRL_RESET;
      chan_enable_reg <= 16'h0000;
      chan_diag_enable_reg <= 16'h0000;
    end
    else if (wr_ctrl)
      ctrl_reg <= pwdata;
    else if (wr_chen)
    begin
      chan_enable_reg <= pwdata[15:0];
      chan_diag_enable_reg <= pwdata[31:16];
    end
  end

  // ----------------------------------------
  // flags: set wins over clear
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_open_flag <= 16'h0000;
      chan_short_flag <= 16'h0000;
      chan_single_short_flag <= 16'h0000;
      {out_flag, low_supply_flag, supply_under_flag} <= 3'b000;
      {ref_flag, overtemp_flag, nvm_checksum_flag} <= 3'b000;
      power_flag <= 1'b1;
      err_flag <= 1'b1;
      failsafe_flag <= 1'b0;
    end
    else
    begin
      chan_open_flag <= (clr_fault ? 16'h0000 : chan_open_flag) | open_ev;
      chan_short_flag <= (clr_fault ? 16'h0000 : chan_short_flag) | short_ev;
      chan_single_short_flag <= (clr_fault ? 16'h0000 :
        chan_single_short_flag) | sls_ev;
      out_flag <= (out_flag && !clr_fault) || out_rep;
      low_supply_flag <= (low_supply_flag && !clr_fault) || lowsup_set;
      supply_under_flag <= (supply_under_flag && !clr_fault) || uv_on;
      ref_flag <= (ref_flag && !clr_fault) || ref_on;
      overtemp_flag <= (overtemp_flag && !clr_fault) || tsd_on;
      nvm_checksum_flag <= (nvm_checksum_flag && !clr_fault) || crc_ev;
      power_flag <= (power_flag && !clr_por) || !rails_good;
      err_flag <= (err_flag && !clr_por && !clr_fault) || err_set ||
        !rails_good;
      failsafe_flag <= (failsafe_flag && !clr_fs) || wd_over;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_tick_reg <= 10'h000;
      wd_cnt_reg <= 4'h0;
    end
    else if (frame_ok || !is_normal || wd_period == 4'h0)
    begin
      wd_tick_reg <= 10'h000;
      wd_cnt_reg <= 4'h0;
    end
    else
    begin
      wd_tick_reg <= wd_tick ? 10'h000 : wd_tick_reg + 10'h001;
      if (wd_tick && wd_cnt_reg != wd_period)
        wd_cnt_reg <= wd_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // fault pin and outputs
  // ----------------------------------------
  // a new pulse request restarts the pulse; constant hold masks it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt_reg <= 13'h0000;
    else if (pulse_req)
      pulse_cnt_reg <= 13'(`LFFM_PULSE_CYC);
    else if (pulse_cnt_reg != 13'h0000)
      pulse_cnt_reg <= pulse_cnt_reg - 13'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_off_reg <= 16'hffff;
    else if (!running || all_off)
      chan_off_reg <= 16'hffff;
    else if (is_fs)
      chan_off_reg <= fs_kill;
    else
      chan_off_reg <= 16'h0000;
  end

  assign chan_out_on = chan_enable_reg & ~chan_off_reg;
  // open drain: output level is always low, enable asserts the sink
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe = const_req || pulse_cnt_reg != 13'h0000;

  // ----------------------------------------
  // apb read
  // ----------------------------------------
  // spare bits read 0; state sits at bits 13:12
  wire [31:0] stat_word = {18'h0000, state_reg, 3'b000, failsafe_flag,
    nvm_checksum_flag, overtemp_flag, ref_flag, supply_under_flag,
    low_supply_flag, out_flag, err_flag, power_flag};
  always_comb
  begin
    unique case (paddr)
      `LFFM_CTRL_ADDR: prdata = ctrl_reg;
      `LFFM_CHEN_ADDR: prdata = {chan_diag_enable_reg, chan_enable_reg};
      `LFFM_STAT_ADDR: prdata = stat_word;
      `LFFM_OPEN_ADDR: prdata = {16'h0000, chan_open_flag};
      `LFFM_SHORT_ADDR: prdata = {16'h0000, chan_short_flag};
      `LFFM_SLS_ADDR: prdata = {16'h0000, chan_single_short_flag};
      `LFFM_OUT_ADDR: prdata = {15'h0000, fault_pin_in, chan_out_on};
      default: prdata = 32'h0000_0000;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  masked_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|open_ev && m_open && !short_rep && !sls_rep && !out_flag)
    |=> !out_flag) else $error("masked open set summary");
  open_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    open_rep |=> fault_pin_oe [*8]) else $error("no open pulse");
  short_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    short_ev[0] |=> chan_short_flag[0]) else $error("short lost");
  por_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rails_good |-> fault_pin_oe ##1 state_reg == lffm_pkg::LFFM_POR)
    else $error("lockout not handled");
  uv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    uv_on |=> chan_out_on == 16'h0000) else $error("uv outputs on");
  tsd_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    tsd_on ##1 !clr_fault |=> overtemp_flag) else $error("tsd");
  wd_fs_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_over && rails_good |=> failsafe_flag && is_fs)
    else $error("wd no fs");
  wd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (is_normal && wd_period == 4'h0) |=> !is_fs) else $error("wd");
  pin_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
    const_req |-> fault_pin_oe) else $error("constant lost");
  low_sup_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_supply |-> open_ev == 16'h0000 && sls_ev == 16'h0000)
    else $error("low supply detect");

  // ----------------------------------------
  // checks: flags, clears and fail-safe
  // ----------------------------------------
  sls_flag_a: assert property
    (@(posedge pclk) disable iff (!presetn)
    sls_ev[0] |=> chan_single_short_flag[0]) else $error("sls lost");
  sls_enable_a: assert property
    (@(posedge pclk) disable iff (!presetn) !ctrl_reg[`LFFM_CTRL_SINGLE_SHORT_DETECT_EN] &&
    !clr_fault |=> $stable(chan_single_short_flag)) else $error("sls on");
  crc_flag_a: assert property
    (@(posedge pclk) disable iff (!presetn) crc_ev && !m_crc |=>
    nvm_checksum_flag && err_flag && fault_pin_oe) else $error("crc");
  fs_all_off_a: assert property
    (@(posedge pclk) disable iff (!presetn) is_fs && all_off_on_fault &&
    |(led_fault & diag_ok) |=> chan_out_on == 16'h0000) else $error("all_off_on_fault");
  fs_one_off_a: assert property
    (@(posedge pclk) disable iff (!presetn) is_fs && !all_off_on_fault && !all_off |=>
    (chan_off_reg & ~$past(led_fault)) == 16'h0000) else $error("healthy");
  por_flags_a: assert property
    (@(posedge pclk) disable iff (!presetn)
    !rails_good |=> power_flag && err_flag) else $error("por flags");
  clr_por_a: assert property
    (@(posedge pclk) disable iff (!presetn) clr_por && rails_good &&
    !err_set |=> !power_flag && !err_flag) else $error("clear power");
  lowsup_latch_a: assert property
    (@(posedge pclk) disable iff (!presetn)
    lowsup_set |=> low_supply_flag && err_flag) else $error("low supply");
  fs_hold_a: assert property
    (@(posedge pclk) disable iff (!presetn) is_fs && (uv_on || ref_on) |->
    fault_pin_oe ##1 chan_out_on == 16'h0000) else $error("fs hold");
  wd_restart_a: assert property
    (@(posedge pclk) disable iff (!presetn) frame_ok |=>
    wd_tick_reg == 10'h000 && wd_cnt_reg == 4'h0) else $error("wd restart");
  uv_pin_a: assert property
    (@(posedge pclk) disable iff (!presetn)
    uv_on && is_normal && !m_uv |-> fault_pin_oe) else $error("uv pin");
  ref_keep_a: assert property
    (@(posedge pclk) disable iff (!presetn) ref_on && is_normal && !uv_on &&
    !tsd_on |=> ref_flag && chan_off_reg == 16'h0000) else $error("ref");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  enter_fs_c: cover property (@(posedge pclk) disable iff (!presetn) wd_over);
  exit_fs_c: cover property (@(posedge pclk) disable iff (!presetn)
    is_fs && clr_fs);
  pulse_c: cover property (@(posedge pclk) disable iff (!presetn)
    pulse_req ##1 !const_req);
  fs_kill_c: cover property (@(posedge pclk) disable iff (!presetn)
    is_fs && |fs_kill);
  restart_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == lffm_pkg::LFFM_POR ##1 state_reg == lffm_pkg::LFFM_START);
endmodule

/* hw/lffm_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz pclk
// Notes: included by the fault manager and its package users
`ifndef LFFM_MAP_SVH
`define LFFM_MAP_SVH
`define LFFM_NCH 16
`define LFFM_CLK_MHZ 100
`define LFFM_PULSE_US 50
`define LFFM_PULSE_CYC (`LFFM_PULSE_US * `LFFM_CLK_MHZ)
`define LFFM_WD_TICK_CYC 1000
// register byte addresses
`define LFFM_CTRL_ADDR 12'h000
`define LFFM_CHEN_ADDR 12'h004
`define LFFM_STAT_ADDR 12'h008
`define LFFM_OPEN_ADDR 12'h00c
`define LFFM_SHORT_ADDR 12'h010
`define LFFM_SLS_ADDR 12'h014
`define LFFM_CLR_ADDR 12'h018
`define LFFM_OUT_ADDR 12'h01c
// ctrl fields
`define LFFM_CTRL_MOPEN 0
`define LFFM_CTRL_MSHORT 1
`define LFFM_CTRL_MSLS 2
`define LFFM_CTRL_MSUPUV 3
`define LFFM_CTRL_MREF 4
`define LFFM_CTRL_MTSD 5
`define LFFM_CTRL_MCRC 6
`define LFFM_CTRL_SINGLE_SHORT_DETECT_EN 7
`define LFFM_CTRL_ALL_OFF_ON_FAULT 8
`define LFFM_CTRL_WD_LSB 12
`define LFFM_CTRL_LST_LSB 16
`define LFFM_CTRL_RESET 32'h0000_0000
// status fields
`define LFFM_ST_POR 0
`define LFFM_ST_ERR 1
`define LFFM_ST_OUT 2
`define LFFM_ST_LOWSUP 3
`define LFFM_ST_SUPUV 4
`define LFFM_ST_REF 5
`define LFFM_ST_TSD 6
`define LFFM_ST_CRC 7
`define LFFM_ST_FS 8
`define LFFM_ST_STATE_LSB 12
// clear fields
`define LFFM_CLR_POR 0
`define LFFM_CLR_FAULT 1
`define LFFM_CLR_FS 2
`define LFFM_LST_MIN_V 4
`endif

/* hw/lffm_pkg.sv */
// Purpose: types for the led fault flag manager
// Assumes: nothing
// Notes: constants live in lffm_map.svh
package lffm_pkg;
  typedef enum logic [1:0]
  {
    LFFM_POR = 2'b00,
    LFFM_START = 2'b01,
    LFFM_NORMAL = 2'b10,
    LFFM_FAILSAFE = 2'b11
  } lffm_state_t;
endpackage

/* verification/led_fault_flag_manager_tb.sv */
// Purpose: self-checking bench for the fault flag manager
// Assumes: 100 MHz pclk, fault pin pulled up outside
// Notes: pulse length is checked at its full 5000 cycles
`include "lffm_map.svh"
module led_fault_flag_manager_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CT = `LFFM_CTRL_ADDR;
  localparam logic [11:0] CH = `LFFM_CHEN_ADDR;
  localparam logic [11:0] ST = `LFFM_STAT_ADDR;
  localparam logic [11:0] OP = `LFFM_OPEN_ADDR;
  localparam logic [11:0] CL = `LFFM_CLR_ADDR;
  localparam logic [11:0] OU = `LFFM_OUT_ADDR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic rails_good = 1'b1;
  logic supply_under = 1'b0;
  logic ref_fault = 1'b0;
  logic overtemp = 1'b0;
  logic [15:0] open_det = 16'h0000;
  logic [15:0] short_det = 16'h0000;
  logic [15:0] sls_det = 16'h0000;
  logic [5:0] supply_volts = 6'h0c;
  logic crc_done = 1'b0;
  logic [7:0] crc_calc = 8'h00;
  logic [7:0] crc_kept = 8'h00;
  logic frame_ok = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, stuck, pin_out, pin_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] chan_out_on;
  int failures = 0;
  int total_checks = 0;
  // open-drain pin: pull-up wins unless the block sinks it
  wire pin = pin_oe ? pin_out : 1'b1;
  always #5 pclk = ~pclk;
  lffm_host host(.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stuck(stuck));
  lffm_fault_mgr DUT(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rails_good(rails_good), .supply_under(supply_under),
    .ref_fault(ref_fault), .overtemp(overtemp), .open_det(open_det),
    .short_det(short_det), .single_short_det(sls_det),
    .supply_volts(supply_volts), .crc_check_done(crc_done),
    .nvm_checksum_computed(crc_calc), .nvm_checksum_stored(crc_kept),
    .frame_ok(frame_ok), .chan_out_on(chan_out_on), .fault_pin_in(pin),
    .fault_pin_out(pin_out), .fault_pin_oe(pin_oe));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] x);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    cmp(r & m, x);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one-cycle detector event; k picks open, short or single-short
  task automatic hit(input int k, input logic [15:0] v);
    @(posedge pclk);
    if (k == 0) open_det <= v;
    else if (k == 1) short_det <= v;
    else sls_det <= v;
    @(posedge pclk);
    open_det <= 16'h0000;
    short_det <= 16'h0000;
    sls_det <= 16'h0000;
  endtask
  task automatic pulse_chk();
    int n;
    n = 0;
    repeat (5200)
    begin
      @(posedge pclk);
      if (pin_oe === 1'b1) n++;
    end
    cmp(n, 5000);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge stuck)
  begin
    failures++;
    final_report();
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(ST, 32'h3003, 32'h2003);
    rd(CT, 32'hffff_ffff, `LFFM_CTRL_RESET);
    host.xfer(1'b0, 12'h020, 32'h0, r, e);
    cmp({31'h0, e}, 32'h1);
    wr(CL, 32'h1);
    rd(ST, 32'h3, 32'h0);
    rd(CL, 32'hffff_ffff, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_open();
    wr(CH, 32'h0001_0009);
    wr(CT, 32'h1);
    hit(0, 16'h0009);
    tick(2);
    rd(OP, 32'hffff, 32'h1);
    rd(ST, 32'h6, 32'h0);
    cmp(pin, 1'b1);
    wr(CL, 32'h2);
    wr(CT, 32'h0);
    hit(0, 16'h0001);
    pulse_chk();
    rd(ST, 32'h6, 32'h6);
    wr(CL, 32'h2);
    // top threshold code, 35 V; masked so no pulse lingers
    wr(CT, 32'h001f_0001);
    supply_volts <= 6'd34;
    hit(0, 16'h0001);
    tick(2);
    rd(OP, 32'hffff, 32'h0);
    supply_volts <= 6'd36;
    hit(0, 16'h0001);
    tick(2);
    rd(OP, 32'hffff, 32'h1);
    supply_volts <= 6'd12;
    wr(CL, 32'h2);
    $display("test open done");
  endtask
  task automatic t_short();
    for (int k = 1; k < 3; k++)
    begin
      wr(CT, (32'h1 << k) | 32'h80);
      hit(k, 16'h0001);
      tick(2);
      rd(OP + 12'(4 * k), 32'hffff, 32'h1);
      rd(ST, 32'h6, 32'h0);
      wr(CL, 32'h2);
      wr(CT, 32'h80);
      hit(k, 16'h0001);
      pulse_chk();
      rd(ST, 32'h6, 32'h6);
      wr(CL, 32'h2);
    end
    wr(CT, 32'h4);
    hit(2, 16'h0001);
    tick(2);
    rd(OP + 12'h8, 32'hffff, 32'h0);
    $display("test short done");
  endtask
  task automatic t_levels();
    logic [31:0] f;
    wr(CT, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      f = 32'h10 << i;
      supply_under <= (i == 0);
      ref_fault <= (i == 1);
      overtemp <= (i == 2);
      tick(3);
      rd(OU, 32'hffff, (i == 1) ? 32'h9 : 32'h0);
      cmp(pin, 1'b0);
      supply_under <= 1'b0;
      ref_fault <= 1'b0;
      overtemp <= 1'b0;
      tick(3);
      rd(OU, 32'hffff, 32'h9);
      cmp(pin, 1'b1);
      rd(ST, f, f);
      wr(CL, 32'h2);
    end
    crc_calc <= 8'h5a;
    crc_kept <= 8'h5b;
    crc_done <= 1'b1;
    @(posedge pclk);
    crc_done <= 1'b0;
    pulse_chk();
    rd(ST, 32'h82, 32'h82);
    crc_kept <= 8'h5a;
    wr(CL, 32'h2);
    $display("test levels done");
  endtask
  task automatic t_failsafe();
    wr(CT, 32'h0000_0100);
    tick(3100);
    rd(ST, 32'h100, 32'h0);
    wr(CT, 32'h0000_2100);
    repeat (6)
    begin
      tick(500);
      frame_ok <= 1'b1;
      @(posedge pclk);
      frame_ok <= 1'b0;
    end
    rd(ST, 32'h100, 32'h0);
    tick(3100);
    rd(ST, 32'h3100, 32'h3100);
    cmp(pin, 1'b1);
    supply_volts <= 6'd3;
    tick(3);
    supply_volts <= 6'd12;
    tick(3);
    rd(ST, 32'ha, 32'ha);
    wr(CL, 32'h2);
    rd(ST, 32'h8, 32'h0);
    // masks are ignored here, so both levels hold the pin
    for (int i = 0; i < 2; i++)
    begin
      supply_under <= (i == 0);
      ref_fault <= (i == 1);
      tick(3);
      cmp(chan_out_on, 32'h0);
      cmp(pin, 1'b0);
      supply_under <= 1'b0;
      ref_fault <= 1'b0;
      tick(3);
      cmp(chan_out_on, 32'h9);
      cmp(pin, 1'b1);
    end
    rd(ST, 32'h22, 32'h22);
    wr(CL, 32'h2);
    // detector is a level: outputs follow it only while it stands
    open_det <= 16'h0001;
    tick(2);
    rd(OU, 32'hffff, 32'h0);
    cmp(chan_out_on, 32'h0);
    wr(CT, 32'h0000_2000);
    tick(2);
    rd(OU, 32'hffff, 32'h8);
    cmp(chan_out_on, 32'h8);
    open_det <= 16'h0000;
    rd(OP, 32'hffff, 32'h1);
    wr(CT, 32'h0);
    wr(CL, 32'h4);
    rd(ST, 32'h3000, 32'h2000);
    $display("test failsafe done");
  endtask
  task automatic t_por();
    rails_good <= 1'b0;
    tick(3);
    cmp(pin, 1'b0);
    rd(ST, 32'h3003, 32'h0003);
    rails_good <= 1'b1;
    tick(3);
    rd(ST, 32'h3003, 32'h2003);
    $display("test power done");
  endtask
  initial
  begin
    tick(16);
    presetn <= 1'b1;
    tick(3);
    t_reset();
    t_open();
    t_short();
    t_levels();
    t_failsafe();
    t_por();
    final_report();
  end
endmodule

/* verification/lffm_host.sv */
// Purpose: apb host standing in for the serial-bus controller
// Assumes: slave answers when pready is high at a rising edge
// Notes: stuck rises if an access phase never completes
module lffm_host
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic stuck
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    stuck = 1'b0;
  end
  // ------------------------------
  // one transfer, held until pready
  // ------------------------------
  // host reads flags and writes clear and exit bits
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1)
      stuck <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // scrambled idle data, so no check leans on a stale word
    pwdata <= ~d;
  endtask
endmodule
